//--- verilog/diag_pkg.sv
package diag_pkg;
	// register byte addresses
	localparam logic [7:0]  ADDR_ERR_EN     = 8'h00;
	localparam logic [7:0]  ADDR_ERR        = 8'h04;
	localparam logic [7:0]  ADDR_STATUS     = 8'h08;
	localparam logic [7:0]  ADDR_DATA       = 8'h0c;
	localparam logic [7:0]  ADDR_MCLK_COUNT = 8'h10;
	localparam logic [7:0]  ADDR_OFFSET     = 8'h14;
	localparam logic [7:0]  ADDR_GAIN       = 8'h18;
	localparam int          ADDR_W          = 8;

	// widths
	localparam int          DATA_W          = 24;
	localparam int          ERR_W           = 12;
	localparam int          EN_W            = 18;
	localparam int          MCNT_W          = 8;
	localparam int          SCNT_W          = 8;
	localparam int          RUN_W           = 5;
	localparam int          PIN_W           = 10;

	// error flag and matching enable bit positions
	localparam int          B_REF           = 0;
	localparam int          B_CAL           = 1;
	localparam int          B_CONV          = 2;
	localparam int          B_SAT           = 3;
	localparam int          B_POS_OV        = 4;
	localparam int          B_POS_UV        = 5;
	localparam int          B_NEG_OV        = 6;
	localparam int          B_NEG_UV        = 7;
	localparam int          B_ASUP          = 8;
	localparam int          B_DSUP          = 9;
	localparam int          B_DECAP         = 10;
	localparam int          B_SCLK          = 11;
	// control-only enable bits
	localparam int          B_ATRIP         = 12;
	localparam int          B_DTRIP         = 13;
	localparam int          B_DECAP_SEL_LO  = 14;
	localparam int          B_DECAP_SEL_HI  = 15;
	localparam int          B_DECAP_TEST    = 16;
	localparam int          B_MCLK_EN       = 17;
	localparam logic [1:0]  DECAP_SEL_ANA   = 2'h1;
	localparam logic [1:0]  DECAP_SEL_DIG   = 2'h2;

	// synchronised pin vector positions
	localparam int          P_SCLK          = 0;
	localparam int          P_CS_N          = 1;
	localparam int          P_REF           = 2;
	localparam int          P_POS_OV        = 3;
	localparam int          P_POS_UV        = 4;
	localparam int          P_NEG_OV        = 5;
	localparam int          P_NEG_UV        = 6;
	localparam int          P_ALOW          = 7;
	localparam int          P_DLOW          = 8;
	localparam int          P_DECAP         = 9;
	localparam logic [9:0]  PIN_RST         = 10'h002;

	// reset values and limits
	localparam logic [17:0] EN_RST          = 18'h00000;
	localparam logic [23:0] OFFSET_RST      = 24'h800000;
	localparam logic [23:0] GAIN_RST        = 24'h400000;
	localparam logic [23:0] OFFSET_MIN      = 24'h07ffff;
	localparam logic [23:0] OFFSET_MAX      = 24'hf80000;
	localparam logic [23:0] CODE_ONES       = 24'hffffff;
	localparam logic [23:0] CODE_ZEROS      = 24'h000000;
	localparam logic [7:0]  MCLK_DIV_LAST   = 8'h82;
	localparam logic [4:0]  SAT_RUN         = 5'h14;
	localparam logic [2:0]  SCLK_MULT_MASK  = 3'h7;

	typedef enum logic [1:0] {
		FRAME_IDLE   = 2'b01,
		FRAME_ACTIVE = 2'b10
	} frame_state_t;
endpackage : diag_pkg

//--- verilog/diag_monitor.sv
`timescale 1ns/1ps
// How it works
// - enabled invalid reference sets reference flag and status summary bit
// - reference flag active: conversion results written as all ones
// - reference flag during calibration blocks coefficient update, flag still set
// - reference flag may set on standby exit; error read clears it
// - calibration, conversion, saturation flags set only with own enable
// - filter overflow/underflow sets conversion flag and clamps ones/zeros
// - conversion flag updates with data register, latched until error read
// - twenty equal consecutive modulator bits set saturation flag
// - offset coefficient out of range: keep offset, set calibration flag
// - full-scale calibration overflow: keep gain, set calibration flag
// - four input over/under flags, each gated by own enable
// - input over/under flags cleared by error register read
// - enabled supply monitors flag regulator undervoltage continuously
// - supply flag holds during undervoltage, clears by read after recovery
// - trip test routes ground into monitor so its flag sets
// - capacitor check turns regulator off, sets flag if output falls
// - only one regulator checked at a time; conversions disturbed
// - capacitor self test disconnects capacitor, forcing capacitor flag only while a regulator capacitor check runs
// - enabled master clock counter steps every 131 clocks, wraps
// - framed serial clock count not multiple of 8 sets flag
// - write frame with bad serial clock count is aborted
// - serial clock count check only with its enable set
module diag_monitor
	import diag_pkg::*;
(
	input  wire logic                          clk_sys,
	input  wire logic                          reset_n,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	// pins from outside the clock domain
	input  wire logic                          serclk,
	input  wire logic                          chip_select_n,
	input  wire logic                          ref_invalid,
	input  wire logic                          pos_over_cmp,
	input  wire logic                          pos_under_cmp,
	input  wire logic                          neg_over_cmp,
	input  wire logic                          neg_under_cmp,
	input  wire logic                          analog_regulator_low,
	input  wire logic                          digital_regulator_low,
	input  wire logic                          decap_output_fall,
	// modulator, filter and calibration engine
	input  wire logic                          mod_strobe,
	input  wire logic                          mod_bit,
	input  wire logic                          conv_valid,
	input  wire logic [diag_pkg::DATA_W-1:0]  conv_data,
	input  wire logic                          filter_overflow,
	input  wire logic                          filter_underflow,
	input  wire logic                          cal_done,
	input  wire logic                          cal_full_scale,
	input  wire logic [diag_pkg::DATA_W-1:0]  cal_coeff,
	input  wire logic                          cal_overflow,
	input  wire logic                          spi_write_frame,
	// results and analog controls
	output logic      [diag_pkg::DATA_W-1:0]  data_out,
	output logic      [diag_pkg::DATA_W-1:0]  offset_coeff,
	output logic      [diag_pkg::DATA_W-1:0]  gain_coeff,
	output logic                               status_fault,
	output logic                               analog_supmon_trip_test,
	output logic                               digital_supmon_trip_test,
	output logic                               analog_regulator_off,
	output logic                               digital_regulator_off,
	output logic                               decap_disconnect,
	output logic                               spi_write_commit,
	output logic                               spi_write_abort
);
	import diag_pkg::*;

	logic [PIN_W-1:0]  pin_meta_reg;
	logic [PIN_W-1:0]  pin_sync_reg;
	logic              sclk_prev_reg;
	logic [EN_W-1:0]   err_en_reg;
	logic [ERR_W-1:0]  err_reg;
	logic [ERR_W-1:0]  err_next;
	logic              status_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] data_next;
	logic [DATA_W-1:0] offset_reg;
	logic [DATA_W-1:0] gain_reg;
	logic [MCNT_W-1:0] mclk_div_reg;
	logic [MCNT_W-1:0] mclk_count_reg;
	logic [RUN_W-1:0]  run_reg;
	logic [RUN_W-1:0]  run_next;
	logic              last_bit_reg;
	logic [SCNT_W-1:0] sclk_cnt_reg;
	frame_state_t      frame_reg;
	logic              commit_reg;
	logic              abort_reg;
	logic [31:0]       hrdata_reg;
	logic              wr_pend_reg;
	logic [ADDR_W-1:0] wr_addr_reg;

	// bus decode
	wire               addr_phase   = hsel & hready & htrans[1];
	wire [ADDR_W-1:0]  addr_lo      = haddr[ADDR_W-1:0];
	wire               rd_err       = addr_phase & ~hwrite & (addr_lo == ADDR_ERR);
	wire               wr_en_reg    = wr_pend_reg & (wr_addr_reg == ADDR_ERR_EN);
	wire               wr_offset    = wr_pend_reg & (wr_addr_reg == ADDR_OFFSET);
	wire               wr_gain      = wr_pend_reg & (wr_addr_reg == ADDR_GAIN);
	wire [31:0]        rd_mux       =
		(addr_lo == ADDR_ERR_EN)     ? {{(32-EN_W){1'b0}}, err_en_reg} :
		(addr_lo == ADDR_ERR)        ? {{(32-ERR_W){1'b0}}, err_reg} :
		(addr_lo == ADDR_STATUS)     ? {31'h00000000, status_reg} :
		(addr_lo == ADDR_DATA)       ? {{(32-DATA_W){1'b0}}, data_reg} :
		(addr_lo == ADDR_MCLK_COUNT) ? {{(32-MCNT_W){1'b0}}, mclk_count_reg} :
		(addr_lo == ADDR_OFFSET)     ? {{(32-DATA_W){1'b0}}, offset_reg} :
		(addr_lo == ADDR_GAIN)       ? {{(32-DATA_W){1'b0}}, gain_reg} :
		32'h00000000;

	// synchronised pins
	wire               sclk_s       = pin_sync_reg[P_SCLK];
	wire               cs_active    = ~pin_sync_reg[P_CS_N];
	wire               sclk_rise    = sclk_s & ~sclk_prev_reg;
	wire [1:0]         decap_sel    = err_en_reg[B_DECAP_SEL_HI:B_DECAP_SEL_LO];

	// capacitor check single regulator
	// one regulator only
	wire               decap_ana    = (decap_sel == DECAP_SEL_ANA);
	wire               decap_dig    = (decap_sel == DECAP_SEL_DIG);
	wire               decap_run    = decap_ana | decap_dig;

	// trip tests force the monitor input low
	// ground routed in
	wire               asup_low     = pin_sync_reg[P_ALOW] | err_en_reg[B_ATRIP];
	wire               dsup_low     = pin_sync_reg[P_DLOW] | err_en_reg[B_DTRIP];

	// fault conditions still present
	wire  [ERR_W-1:0]  cond_vec;
	wire  [ERR_W-1:0]  set_vec;

	assign cond_vec[B_REF]    = err_en_reg[B_REF] & pin_sync_reg[P_REF];
	assign cond_vec[B_CAL]    = 1'b0;
	assign cond_vec[B_CONV]   = 1'b0;
	assign cond_vec[B_SAT]    = 1'b0;
	assign cond_vec[B_POS_OV] = err_en_reg[B_POS_OV] & pin_sync_reg[P_POS_OV];
	assign cond_vec[B_POS_UV] = err_en_reg[B_POS_UV] & pin_sync_reg[P_POS_UV];
	assign cond_vec[B_NEG_OV] = err_en_reg[B_NEG_OV] & pin_sync_reg[P_NEG_OV];
	assign cond_vec[B_NEG_UV] = err_en_reg[B_NEG_UV] & pin_sync_reg[P_NEG_UV];
	assign cond_vec[B_ASUP]   = err_en_reg[B_ASUP] & asup_low;
	assign cond_vec[B_DSUP]   = err_en_reg[B_DSUP] & dsup_low;
	assign cond_vec[B_DECAP]  = decap_run & (pin_sync_reg[P_DECAP] | err_en_reg[B_DECAP_TEST]);
	assign cond_vec[B_SCLK]   = 1'b0;

	// conversion path
	wire               conv_bad     = conv_valid & (filter_overflow | filter_underflow);
	wire               ref_flag     = err_reg[B_REF] | cond_vec[B_REF];

	// calibration checks
	wire               off_range_ok = (cal_coeff >= OFFSET_MIN) & (cal_coeff <= OFFSET_MAX);
	wire               off_bad      = cal_done & ~cal_full_scale & ~off_range_ok;
	wire               gain_bad     = cal_done & cal_full_scale & cal_overflow;
	wire               off_load     = cal_done & ~cal_full_scale & off_range_ok & ~ref_flag;
	wire               gain_load    = cal_done & cal_full_scale & ~cal_overflow & ~ref_flag;

	// saturation run length
	wire               same_bit     = (mod_bit == last_bit_reg);
	assign run_next = ~mod_strobe ? run_reg :
		~same_bit ? RUN_W'(1) :
		(run_reg >= SAT_RUN) ? SAT_RUN : RUN_W'(run_reg + 1'b1);

	// serial frame end and count check
	wire               frame_end    = (frame_reg == FRAME_ACTIVE) & ~cs_active;
	wire               sclk_bad     = frame_end & ((sclk_cnt_reg[2:0] & SCLK_MULT_MASK) != 3'h0);
	wire               sclk_chk     = err_en_reg[B_SCLK];

	// calibration, conversion, saturation events each gated by enable
	assign set_vec[B_CAL]  = err_en_reg[B_CAL] & (off_bad | gain_bad);
	assign set_vec[B_CONV] = err_en_reg[B_CONV] & conv_bad;
	assign set_vec[B_SAT]  = err_en_reg[B_SAT] & mod_strobe & (run_next >= SAT_RUN);
	assign set_vec[B_SCLK] = sclk_chk & sclk_bad;
	assign set_vec[B_REF]     = cond_vec[B_REF];
	assign set_vec[B_POS_OV]  = cond_vec[B_POS_OV];
	assign set_vec[B_POS_UV]  = cond_vec[B_POS_UV];
	assign set_vec[B_NEG_OV]  = cond_vec[B_NEG_OV];
	assign set_vec[B_NEG_UV]  = cond_vec[B_NEG_UV];
	assign set_vec[B_ASUP]    = cond_vec[B_ASUP];
	assign set_vec[B_DSUP]    = cond_vec[B_DSUP];
	assign set_vec[B_DECAP]   = cond_vec[B_DECAP];

	// read clears flags whose fault is gone; set wins
	wire [ERR_W-1:0]   clr_mask     = rd_err ? ~cond_vec : {ERR_W{1'b0}};
	assign err_next = (err_reg & ~clr_mask) | set_vec;

	assign data_next = ~conv_valid ? data_reg :
		ref_flag ? CODE_ONES :
		filter_overflow ? CODE_ONES :
		filter_underflow ? CODE_ZEROS : conv_data;

	// pin synchronisers
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_meta_reg  <= PIN_RST;
			pin_sync_reg  <= PIN_RST;
			sclk_prev_reg <= 1'b0;
		end
		else
		begin
			pin_meta_reg  <= {decap_output_fall, digital_regulator_low, analog_regulator_low,
				neg_under_cmp, neg_over_cmp, pos_under_cmp, pos_over_cmp, ref_invalid,
				chip_select_n, serclk};
			pin_sync_reg  <= pin_meta_reg;
			sclk_prev_reg <= sclk_s;
		end
	end

	// error flags, status and conversion data
	// summary bit
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			err_reg    <= {ERR_W{1'b0}};
			status_reg <= 1'b0;
			data_reg   <= CODE_ZEROS;
		end
		else
		begin
			err_reg    <= err_next;
			status_reg <= |err_next;
			data_reg   <= data_next;
		end
	end

	// software registers and coefficients
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			err_en_reg <= EN_RST;
			offset_reg <= OFFSET_RST;
			gain_reg   <= GAIN_RST;
		end
		else
		begin
			if (wr_en_reg)
				err_en_reg <= hwdata[EN_W-1:0];
			if (off_load)
				offset_reg <= cal_coeff;
			else if (wr_offset)
				offset_reg <= hwdata[DATA_W-1:0];
			if (gain_load)
				gain_reg <= cal_coeff;
			else if (wr_gain)
				gain_reg <= hwdata[DATA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mclk_div_reg   <= {MCNT_W{1'b0}};
			mclk_count_reg <= {MCNT_W{1'b0}};
		end
		else if (err_en_reg[B_MCLK_EN])
		begin
			mclk_div_reg <= (mclk_div_reg == MCLK_DIV_LAST) ? {MCNT_W{1'b0}}
				: MCNT_W'(mclk_div_reg + 1'b1);
			if (mclk_div_reg == MCLK_DIV_LAST)
				mclk_count_reg <= MCNT_W'(mclk_count_reg + 1'b1);
		end
		else
			mclk_div_reg <= {MCNT_W{1'b0}};
	end

	// modulator run tracking
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_reg      <= {RUN_W{1'b0}};
			last_bit_reg <= 1'b0;
		end
		else
		begin
			run_reg <= run_next;
			if (mod_strobe)
				last_bit_reg <= mod_bit;
		end
	end

	// serial frame tracking
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_reg    <= FRAME_IDLE;
			sclk_cnt_reg <= {SCNT_W{1'b0}};
			commit_reg   <= 1'b0;
			abort_reg    <= 1'b0;
		end
		else
		begin
			commit_reg <= 1'b0;
			abort_reg  <= 1'b0;
			case (frame_reg)
				FRAME_IDLE:
				begin
					sclk_cnt_reg <= {SCNT_W{1'b0}};
					if (cs_active)
						frame_reg <= FRAME_ACTIVE;
				end
				FRAME_ACTIVE:
				begin
					if (sclk_rise)
						sclk_cnt_reg <= SCNT_W'(sclk_cnt_reg + 1'b1);
					if (!cs_active)
					begin
						frame_reg <= FRAME_IDLE;
						abort_reg  <= spi_write_frame & sclk_chk & sclk_bad;
						commit_reg <= spi_write_frame & ~(sclk_chk & sclk_bad);
					end
				end
				default:
					frame_reg <= FRAME_IDLE;
			endcase
		end
	end

	// ahb-lite slave, zero wait states
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hrdata_reg  <= 32'h00000000;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= {ADDR_W{1'b0}};
		end
		else
		begin
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr_reg <= addr_lo;
			if (addr_phase & ~hwrite)
				hrdata_reg <= rd_mux;
		end
	end

	assign hrdata                   = hrdata_reg;
	assign hreadyout                = reset_n;
	assign hresp                    = 1'b0;
	assign data_out                 = data_reg;
	assign offset_coeff             = offset_reg;
	assign gain_coeff               = gain_reg;
	assign status_fault             = status_reg;
	assign analog_supmon_trip_test  = err_en_reg[B_ATRIP];
	assign digital_supmon_trip_test = err_en_reg[B_DTRIP];
	assign analog_regulator_off     = decap_ana;
	assign digital_regulator_off    = decap_dig;
	assign decap_disconnect         = err_en_reg[B_DECAP_TEST];
	assign spi_write_commit         = commit_reg;
	assign spi_write_abort          = abort_reg;
endmodule : diag_monitor

//--- verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
(
	output logic serclk,
	output logic chip_select_n,
	output logic spi_write_frame
);
	initial
	begin
		serclk = 1'b0;
		chip_select_n = 1'b1;
		spi_write_frame = 1'b0;
	end
	task automatic frame(input int pulses, input logic wr);
		#37;
		spi_write_frame = wr;
		chip_select_n = 1'b0;
		repeat (pulses)
		begin
			#200 serclk = 1'b1;
			#200 serclk = 1'b0;
		end
		#200 chip_select_n = 1'b1;
		#600 spi_write_frame = 1'b0;
	endtask : frame
endmodule : spi_host_model

//--- verif/diag_monitor_checker.sv
`timescale 1ns/1ps
module diag_monitor_checker
(
	input wire logic                        clk_sys,
	input wire logic                        reset_n,
	input wire logic                        hsel,
	input wire logic [31:0]                 haddr,
	input wire logic [1:0]                  htrans,
	input wire logic                        hwrite,
	input wire logic                        hready,
	input wire logic [31:0]                 hwdata,
	input wire logic                        ref_invalid,
	input wire logic                        conv_valid,
	input wire logic [diag_pkg::DATA_W-1:0] conv_data,
	input wire logic                        filter_overflow,
	input wire logic                        filter_underflow,
	input wire logic                        cal_done,
	input wire logic                        cal_full_scale,
	input wire logic [diag_pkg::DATA_W-1:0] cal_coeff,
	input wire logic                        cal_overflow,
	input wire logic [diag_pkg::DATA_W-1:0] data_out,
	input wire logic [diag_pkg::DATA_W-1:0] offset_coeff,
	input wire logic [diag_pkg::DATA_W-1:0] gain_coeff,
	input wire logic                        status_fault,
	input wire logic                        analog_supmon_trip_test,
	input wire logic                        analog_regulator_off,
	input wire logic                        digital_regulator_off,
	input wire logic                        spi_write_commit,
	input wire logic                        spi_write_abort
);
	import diag_pkg::*;
	logic       wph;
	logic [7:0] wad;
	logic [2:0] quiet;
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wph   <= 1'b0;
			wad   <= 8'h00;
			quiet <= 3'h0;
		end
		else
		begin
			wph   <= hsel && hready && htrans[1] && hwrite;
			wad   <= haddr[7:0];
			quiet <= ref_invalid ? 3'h0 : quiet + 3'(quiet != 3'h7);
		end
	end
	// reference quiet for a while and no flag latched
	wire ref_ok = (quiet == 3'h7) && !status_fault;
	wire wr_ofs = wph && (wad == ADDR_OFFSET);
	wire wr_gain = wph && (wad == ADDR_GAIN);
	wire in_rng = (cal_coeff >= OFFSET_MIN) && (cal_coeff <= OFFSET_MAX);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	AST_OVF_ONES: assert property (
		conv_valid && filter_overflow |=> data_out == CODE_ONES)
		else $error("overflow result not all ones");
	AST_CONV_PASS: assert property (
		conv_valid && !filter_overflow && !filter_underflow && ref_ok
		|=> data_out == $past(conv_data)) else $error("clean result altered");
	AST_OFS_REJECT: assert property (
		cal_done && !cal_full_scale && !in_rng && !wr_ofs |=> $stable(offset_coeff))
		else $error("offset out of range loaded");
	AST_OFS_LOAD: assert property (
		cal_done && !cal_full_scale && in_rng && ref_ok |=> offset_coeff == $past(cal_coeff))
		else $error("offset in range not loaded");
	AST_GAIN_KEEP: assert property (
		cal_done && cal_full_scale && cal_overflow && !wr_gain |=> $stable(gain_coeff))
		else $error("gain loaded on overflow");
	AST_TRIP_WRITE: assert property (
		wph && wad == ADDR_ERR_EN |=> analog_supmon_trip_test == $past(hwdata[B_ATRIP]))
		else $error("trip test output wrong");
	AST_ONE_REG: assert property (
		!(analog_regulator_off && digital_regulator_off)) else $error("both regulators off");
	AST_WRITE_END: assert property (
		spi_write_abort |-> !spi_write_commit ##1 !spi_write_abort)
		else $error("abort not a lone pulse");
	COV_CLAMP: cover property (conv_valid && filter_overflow);
	COV_REJECT: cover property (cal_done && !in_rng);
	COV_ABORT: cover property (spi_write_abort);
endmodule : diag_monitor_checker
bind diag_monitor diag_monitor_checker u_chk (.*);

//--- verif/adc_diagnostic_error_monitor_bench.sv
`timescale 1ns/1ps
module adc_diagnostic_error_monitor_bench;
	import diag_pkg::*;
	logic clk_sys, reset_n, hsel, hwrite, hreadyout, serclk, chip_select_n, spi_write_frame;
	logic mod_strobe, mod_bit, conv_valid, filter_overflow, filter_underflow, cal_done;
	logic cal_full_scale, cal_overflow, analog_supmon_trip_test, digital_supmon_trip_test;
	logic decap_disconnect, analog_regulator_off, digital_regulator_off;
	logic spi_write_commit, spi_write_abort;
	logic [1:0]        htrans;
	logic [7:0]        cmp;
	logic [31:0]       haddr, hwdata, hrdata, rd, en;
	logic [DATA_W-1:0] conv_data, cal_coeff, data_out, offset_coeff, gain_coeff, eo;
	int                err_total, cmp_count, n_commit, n_abort;
	int                fb[8] = '{0, 4, 5, 6, 7, 8, 9, 10};
	int                np[4] = '{7, 16, 9, 12};
	logic [31:0]       tp[3] = '{32'h1100, 32'h2200, 32'h14400};
	logic [23:0]       oc[4] = '{24'h07fffe, 24'h07ffff, 24'hf80001, 24'hf80000};
	diag_monitor DUT (.*, .hsize(3'h2), .hready(hreadyout), .ref_invalid(cmp[0]),
		.pos_over_cmp(cmp[1]), .pos_under_cmp(cmp[2]), .neg_over_cmp(cmp[3]),
		.neg_under_cmp(cmp[4]), .analog_regulator_low(cmp[5]),
		.digital_regulator_low(cmp[6]), .decap_output_fall(cmp[7]),
		.hresp(), .status_fault());
	spi_host_model u_host (.serclk(serclk), .chip_select_n(chip_select_n),
		.spi_write_frame(spi_write_frame));
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		n_commit += int'(spi_write_commit === 1'b1);
		n_abort += int'(spi_write_abort === 1'b1);
	end
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rc
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle
	task automatic conv(input logic [23:0] d, input logic o, input logic u);
		@(posedge clk_sys);
		conv_valid <= 1'b1;
		conv_data <= d;
		filter_overflow <= o;
		filter_underflow <= u;
		@(posedge clk_sys);
		conv_valid <= 1'b0;
	endtask : conv
	task automatic cal(input logic fs, input logic [23:0] c, input logic o);
		@(posedge clk_sys);
		cal_done <= 1'b1;
		cal_full_scale <= fs;
		cal_coeff <= c;
		cal_overflow <= o;
		@(posedge clk_sys);
		cal_done <= 1'b0;
	endtask : cal
	task automatic mod(input int n, input logic b);
		repeat (n)
		begin
			@(posedge clk_sys);
			mod_strobe <= 1'b1;
			mod_bit <= b;
			@(posedge clk_sys);
			mod_strobe <= 1'b0;
		end
	endtask : mod
	initial
	begin
		#3000000;
		err_total++;
		results();
	end
	initial
	begin
		{hsel, hwrite, htrans, haddr, hwdata, cmp, mod_strobe, mod_bit} = '0;
		{conv_valid, conv_data, filter_overflow, filter_underflow} = '0;
		{cal_done, cal_full_scale, cal_coeff, cal_overflow} = '0;
		{err_total, cmp_count, n_commit, n_abort} = '0;
		eo = OFFSET_RST;
		reset_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		rc("offset_rst", ADDR_OFFSET, {8'h0, OFFSET_RST});
		rc("gain_rst", ADDR_GAIN, {8'h0, GAIN_RST});
		ahb(1'b1, 8'h40, 32'hffffffff);
		rc("unmapped", 8'h40, 32'h0);
		for (int k = 0; k < 8; k++)
		begin
			en = (32'h1 << fb[k]) | ((k == 7) ? 32'h4000 : 32'h0);
			cmp <= 8'h1 << k;
			idle(6);
			rc("err_off", ADDR_ERR, 32'h0);
			ahb(1'b1, ADDR_ERR_EN, en);
			idle(6);
			rc("err_on", ADDR_ERR, en & 32'hfff);
			rc("status", ADDR_STATUS, 32'h1);
			rc("err_held", ADDR_ERR, en & 32'hfff);
			cmp <= 8'h0;
			idle(6);
			rc("err_latched", ADDR_ERR, en & 32'hfff);
			rc("err_clear", ADDR_ERR, 32'h0);
			ahb(1'b1, ADDR_ERR_EN, 32'h0);
		end
		for (int k = 0; k < 3; k++)
		begin
			ahb(1'b1, ADDR_ERR_EN, tp[k]);
			idle(6);
			rc("err_trip", ADDR_ERR, 32'h100 << k);
			@(negedge clk_sys);
			chk("test_pins", 32'h1 << k, {29'h0, decap_disconnect, digital_supmon_trip_test,
				analog_supmon_trip_test});
			ahb(1'b1, ADDR_ERR_EN, 32'h0);
			idle(6);
			rc("err_trip_gone", ADDR_ERR, 32'h100 << k);
		end
		for (int s = 1; s < 4; s++)
		begin
			ahb(1'b1, ADDR_ERR_EN, 32'(s << 14));
			@(negedge clk_sys);
			chk("reg_off", (s == 3) ? 32'h0 : 32'(s), {30'h0, digital_regulator_off,
				analog_regulator_off});
		end
		ahb(1'b1, ADDR_ERR_EN, 32'h0);
		conv(24'h123456, 1'b1, 1'b0);
		rc("conv_gated", ADDR_ERR, 32'h0);
		rc("data_ones", ADDR_DATA, 32'hffffff);
		ahb(1'b1, ADDR_ERR_EN, 32'h4);
		conv(24'h123456, 1'b0, 1'b1);
		rc("data_zeros", ADDR_DATA, 32'h0);
		rc("conv_flag", ADDR_ERR, 32'h4);
		rc("conv_clear", ADDR_ERR, 32'h0);
		conv(24'h123456, 1'b0, 1'b0);
		rc("data_pass", ADDR_DATA, 32'h123456);
		ahb(1'b1, ADDR_ERR_EN, 32'h3);
		cmp <= 8'h1;
		idle(6);
		conv(24'h654321, 1'b0, 1'b0);
		rc("data_ref", ADDR_DATA, 32'hffffff);
		cal(1'b0, 24'h100000, 1'b0);
		rc("ofs_ref", ADDR_OFFSET, {8'h0, OFFSET_RST});
		rc("err_ref", ADDR_ERR, 32'h1);
		cmp <= 8'h0;
		idle(6);
		rc("err_ref_gone", ADDR_ERR, 32'h1);
		ahb(1'b1, ADDR_ERR_EN, 32'h2);
		for (int k = 0; k < 4; k++)
		begin
			cal(1'b0, oc[k], 1'b0);
			eo = (k % 2) ? oc[k] : eo;
			@(negedge clk_sys);
			chk("offset", {8'h0, eo}, {8'h0, offset_coeff});
			rc("cal_flag", ADDR_ERR, (k % 2) ? 32'h0 : 32'h2);
		end
		cal(1'b1, 24'h500000, 1'b1);
		rc("cal_fs_flag", ADDR_ERR, 32'h2);
		rc("gain_kept", ADDR_GAIN, {8'h0, GAIN_RST});
		cal(1'b1, 24'h500000, 1'b0);
		rc("gain_load", ADDR_GAIN, 32'h500000);
		ahb(1'b1, ADDR_ERR_EN, 32'h8);
		mod(19, 1'b1);
		mod(19, 1'b0);
		rc("sat_19", ADDR_ERR, 32'h0);
		mod(1, 1'b0);
		rc("sat_20", ADDR_ERR, 32'h8);
		for (int k = 0; k < 4; k++)
		begin
			ahb(1'b1, ADDR_ERR_EN, (k == 0) ? 32'h0 : 32'h800);
			n_commit = 0;
			n_abort = 0;
			u_host.frame(np[k], k != 3);
			idle(4);
			rc("sclk_flag", ADDR_ERR, (k > 1) ? 32'h800 : 32'h0);
			chk("commits", (k < 2) ? 32'h1 : 32'h0, 32'(n_commit));
			chk("aborts", (k == 2) ? 32'h1 : 32'h0, 32'(n_abort));
		end
		ahb(1'b1, ADDR_ERR_EN, 32'h20000);
		idle(131 * 3 + 60);
		repeat (4) rc("mclk", ADDR_MCLK_COUNT, 32'h3);
		idle(131 * 256);
		repeat (4) rc("mclk_wrap", ADDR_MCLK_COUNT, 32'h3);
		results();
	end
endmodule : adc_diagnostic_error_monitor_bench
